// >>> hdl/dss_program_logic.sv
`timescale 1ns/1ps
`include "dss_defines.svh"
// What this block does
// - host sends msb first; bits shift into 22-bit register on serial clock rise
// - load strobe rise copies shift register into latch picked by last two bits
// - code 00 loads second loop reference, 01 first loop reference, 15-bit divider
// - reference ratio is bits 1..15 binary, 3 to 32767; host never below 3
// - code 10 loads second loop feedback, 11 first; 7-bit swallow, 11-bit main
// - swallow ratio is feedback bits 1..7, values 0 to 127
// - main ratio is feedback bits 8..18, 3 to 2047; host never below 3
// - total feedback division is modulus times main plus swallow, modulus 64/128
// - feedback bit 19 picks 64/65 when zero, 128/129 when one
// - reference bit 16 sets detector polarity; one positive, zero negative
// - reference bit 17 picks pump current; low is quarter of high
// - reference bit 18 one floats that loop's charge pump output
// - feedback bit 20 one requests power-down of that loop
// - all four lock and function bits zero drives the status pin low
// - lock bits choose lock indication of second, first or both loops
// - one function bit set shows reference or feedback divider output
// - both function bits, no lock bits: fast acquisition follows pump current
// - both function bits with lock bits reset counters and float pumps
// - after counter reset feedback restarts aligned with reference counter
// - power-down waits for pump idle if float bit zero, else immediate
// - sleeping loop holds dividers loaded; oscillator stops only when both sleep
// - strobe latching zero sleep bit wakes loop immediately
module dss_program_logic
  import dss_pkg::*;
#(
  parameter int REF_W = 15,
  parameter int SW_W = 7,
  parameter int MAIN_W = 11
) (
  // system
  input wire logic clock,
  input wire logic rst,
  // serial link, own clock domain
  input wire logic serialClock,
  input wire logic serialData,
  input wire logic loadStrobe,
  // loop inputs: [0] first loop, [1] second loop
  input wire logic [1:0] vcoPrescaled,
  input wire logic [1:0] pumpActive,
  // loop controls
  output logic [1:0] detectorPolarity,
  output logic [1:0] pumpCurrentHigh,
  output logic [1:0] pumpFloat,
  output logic [1:0] prescalerHigh,
  output logic [1:0] loopSleep,
  output logic [1:0] referenceTick,
  output logic [1:0] feedbackTick,
  output logic [1:0] pumpUp,
  output logic [1:0] pumpDown,
  output logic oscillatorEnable,
  // status pin
  output logic multifunctionStatusPin
);
  localparam int SW = `DSS_SHIFT_W;

  // stored words drop the two select bits, so every field sits two lower
  localparam int POL_POS = `DSS_POL_BIT - 2;
  localparam int CUR_POS = `DSS_CUR_BIT - 2;
  localparam int FLOAT_POS = `DSS_FLOAT_BIT - 2;
  localparam int LOCK_POS = `DSS_LOCK_BIT - 2;
  localparam int FUNC_POS = `DSS_FUNC_BIT - 2;
  localparam int REF_POS = `DSS_REF_LSB - 2;
  localparam int SWL_POS = `DSS_SW_LSB - 2;
  localparam int MAIN_POS = `DSS_MAIN_LSB - 2;
  localparam int PRE_POS = `DSS_PRE_BIT - 2;
  localparam int SLEEP_POS = `DSS_SLEEP_BIT - 2;

  // link domain: shift register on serial clock
  logic [SW-1:0] shiftWord;
  always_ff @(posedge serialClock) begin
    shiftWord <= {shiftWord[SW-2:0], serialData};
  end

  // strobe and its word cross by two-flop sync; word is stable while strobe high
  logic strobeMeta, strobeSync, strobeLast;
  logic [SW-1:0] wordMeta, wordSync;
  always_ff @(posedge clock) begin
    if (rst) begin
      strobeMeta <= 1'b0;
      strobeSync <= 1'b0;
      strobeLast <= 1'b0;
    end else begin
      strobeMeta <= loadStrobe;
      strobeSync <= strobeMeta;
      strobeLast <= strobeSync;
    end
  end

  // word rides the same two stages so it lines up with the strobe edge
  always_ff @(posedge clock) begin
    if (rst) begin
      wordMeta <= '0;
      wordSync <= '0;
    end else begin
      wordMeta <= shiftWord;
      wordSync <= wordMeta;
    end
  end

  logic loadPulse;
  assign loadPulse = strobeSync & ~strobeLast;

  // latches, index 0 first loop, 1 second loop
  logic [19:0] refWord [2];
  logic [19:0] fbWord [2];
  logic [1:0] loadRef, loadFb;
  logic [1:0] selCode;
  assign selCode = wordSync[1:0];

  // one strobe edge touches exactly one latch; the rest keep their contents
  always_comb begin
    loadRef = 2'b00;
    loadFb = 2'b00;
    if (loadPulse) begin
      unique case (selCode)
        `DSS_SEL_REF1: loadRef[0] = 1'b1;
        `DSS_SEL_REF2: loadRef[1] = 1'b1;
        `DSS_SEL_FB1: loadFb[0] = 1'b1;
        `DSS_SEL_FB2: loadFb[1] = 1'b1;
      endcase
    end
  end

  // per-loop divider machinery
  logic [1:0] refPulse, fbPulse, lockedLoop, counterReset, sleepNow;
  logic [1:0] lockSel, funcSel;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gLoop
      logic [REF_W-1:0] refRatio, refCount;
      logic [SW_W-1:0] swRatio, swCount;
      logic [MAIN_W-1:0] mainRatio, mainCount;
      logic [7:0] modulus, preCount;
      logic sleepReq, holdLoad, refHalf, fbHalf;
      logic [3:0] phaseGap;
      logic polBit, curBit, floatBit;
      logic swSlow, preWrap, mainWrap;
      logic pdStop, pdOne, pdBoth;


      always_ff @(posedge clock) begin
        if (rst) begin
          refWord[g] <= '0;
        end else if (loadRef[g]) begin
          refWord[g] <= wordSync[21:2];
        end
      end
      always_ff @(posedge clock) begin
        if (rst) begin
          fbWord[g] <= '0;
        end else if (loadFb[g]) begin
          fbWord[g] <= wordSync[21:2];
        end
      end

      // field positions within the stored 20-bit words (shift bit minus 2)
      assign refRatio = refWord[g][REF_POS +: REF_W];
      assign swRatio = fbWord[g][SWL_POS +: SW_W];
      assign mainRatio = fbWord[g][MAIN_POS +: MAIN_W];
      assign modulus = fbWord[g][PRE_POS] ? `DSS_MOD_HI : `DSS_MOD_LO;
      assign sleepReq = fbWord[g][SLEEP_POS];

      assign lockSel[g] = refWord[g][LOCK_POS];
      assign funcSel[g] = refWord[g][FUNC_POS];
      assign polBit = refWord[g][POL_POS];
      assign curBit = refWord[g][CUR_POS];
      assign floatBit = refWord[g][FLOAT_POS];

      // synchronous sleep waits for pump idle; asynchronous is immediate
      always_ff @(posedge clock) begin
        if (rst) begin
          sleepNow[g] <= 1'b0;
        end else if (!sleepReq) begin
          sleepNow[g] <= 1'b0;
        end else if (floatBit || !pumpActive[g]) begin
          sleepNow[g] <= 1'b1;
        end
      end
      assign holdLoad = sleepNow[g] | counterReset[g];

      // reference divider: pulse every refRatio clocks
      always_ff @(posedge clock) begin
        if (rst || holdLoad || refCount >= refRatio - REF_W'(1)) begin
          refCount <= '0;
        end else begin
          refCount <= refCount + REF_W'(1);
        end
      end
      assign refPulse[g] = !holdLoad && refCount == '0;

      // pulse swallow: P+1 for swallow cycles then P; total P*main + swallow
      assign swSlow = swCount < swRatio;
      assign preWrap = vcoPrescaled[g] && preCount >= modulus - (swSlow ? 8'h00 : 8'h01);
      assign mainWrap = preWrap && mainCount >= mainRatio - MAIN_W'(1);

      always_ff @(posedge clock) begin
        if (rst || holdLoad || preWrap) begin
          preCount <= '0;
        end else if (vcoPrescaled[g]) begin
          preCount <= preCount + 8'h01;
        end
      end

      // released together with the reference counter, so both restart in step
      always_ff @(posedge clock) begin
        if (rst || holdLoad || mainWrap) begin
          mainCount <= '0;
        end else if (preWrap) begin
          mainCount <= mainCount + MAIN_W'(1);
        end
      end

      always_ff @(posedge clock) begin
        if (rst || holdLoad || mainWrap) begin
          swCount <= '0;
        end else if (preWrap && swSlow) begin
          swCount <= swCount + SW_W'(1);
        end
      end
      assign fbPulse[g] = !holdLoad && vcoPrescaled[g] && preCount == '0 && mainCount == '0;

      // phase detector with polarity, float and lock gap
      assign pdStop = rst || holdLoad || floatBit;
      assign pdOne = refPulse[g] ^ fbPulse[g];
      assign pdBoth = refPulse[g] && fbPulse[g];

      always_ff @(posedge clock) begin
        if (pdStop || pdBoth) begin
          pumpUp[g] <= 1'b0;
        end else if (pdOne) begin
          pumpUp[g] <= refPulse[g] ^ ~polBit;
        end
      end

      always_ff @(posedge clock) begin
        if (pdStop || pdBoth) begin
          pumpDown[g] <= 1'b0;
        end else if (pdOne) begin
          pumpDown[g] <= fbPulse[g] ^ ~polBit;
        end
      end

      // gap saturates so a long slip cannot wrap back into the locked window
      always_ff @(posedge clock) begin
        if (pdStop || pdBoth) begin
          phaseGap <= '0;
        end else if (pdOne) begin
          phaseGap <= 4'h1;
        end else if ((pumpUp[g] | pumpDown[g]) && phaseGap != 4'hf) begin
          phaseGap <= phaseGap + 4'h1;
        end
      end
      assign lockedLoop[g] = !(pumpUp[g] | pumpDown[g]) || phaseGap <= `DSS_LOCK_TOL;

      // every loop output is its own flop, so the pins never glitch
      always_ff @(posedge clock) begin
        if (rst) begin
          detectorPolarity[g] <= 1'b0;
        end else begin
          detectorPolarity[g] <= polBit;
        end
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          pumpCurrentHigh[g] <= 1'b0;
        end else begin
          pumpCurrentHigh[g] <= curBit;
        end
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          pumpFloat[g] <= 1'b0;
        end else begin
          pumpFloat[g] <= floatBit | counterReset[g];
        end
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          prescalerHigh[g] <= 1'b0;
        end else begin
          prescalerHigh[g] <= fbWord[g][PRE_POS];
        end
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          loopSleep[g] <= 1'b0;
        end else begin
          loopSleep[g] <= sleepNow[g];
        end
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          referenceTick[g] <= 1'b0;
        end else begin
          referenceTick[g] <= refPulse[g];
        end
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          feedbackTick[g] <= 1'b0;
        end else begin
          feedbackTick[g] <= fbPulse[g];
        end
      end
    end
  endgenerate

  // pin function decode
  dss_pin_mode_t pinMode;
  always_comb begin
    if (funcSel == 2'b00) begin
      pinMode = (lockSel == 2'b00) ? DSS_PIN_OFF : DSS_PIN_LOCK;
    end else if (funcSel == 2'b11) begin
      pinMode = DSS_PIN_CTRL;
    end else begin
      pinMode = DSS_PIN_MON;
    end
  end

  // counter reset: lock bits {first,second} 01 second, 10 first, 11 both
  always_comb begin
    counterReset = (funcSel == 2'b11) ? lockSel : 2'b00;
  end

  logic monLoop;
  assign monLoop = funcSel[0] ? 1'b0 : 1'b1;

  // disabled pin is driven low, never left floating
  logic next_statusPin;
  always_comb begin
    next_statusPin = 1'b0;
    unique case (pinMode)
      DSS_PIN_OFF: begin
        next_statusPin = 1'b0;
      end
      DSS_PIN_LOCK: begin
        next_statusPin = &(lockedLoop | ~lockSel);
      end
      DSS_PIN_MON: begin
        next_statusPin = lockSel[1] ? feedbackTick[monLoop] : referenceTick[monLoop];
      end
      DSS_PIN_CTRL: begin
        next_statusPin = (lockSel == 2'b00) && |pumpCurrentHigh;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      multifunctionStatusPin <= 1'b0;
    end else begin
      multifunctionStatusPin <= next_statusPin;
    end
  end

  // oscillator runs unless both loops sleep
  always_ff @(posedge clock) begin
    if (rst) begin
      oscillatorEnable <= 1'b1;
    end else begin
      oscillatorEnable <= ~&sleepNow;
    end
  end
endmodule

// >>> hdl/dss_defines.svh
`ifndef DSS_DEFINES_SVH
`define DSS_DEFINES_SVH
`define DSS_SHIFT_W 22
`define DSS_SEL_REF2 2'h0
`define DSS_SEL_REF1 2'h1
`define DSS_SEL_FB2 2'h2
`define DSS_SEL_FB1 2'h3
`define DSS_REF_LSB 2
`define DSS_REF_MSB 16
`define DSS_POL_BIT 17
`define DSS_CUR_BIT 18
`define DSS_FLOAT_BIT 19
`define DSS_LOCK_BIT 20
`define DSS_FUNC_BIT 21
`define DSS_SW_LSB 2
`define DSS_SW_MSB 8
`define DSS_MAIN_LSB 9
`define DSS_MAIN_MSB 19
`define DSS_PRE_BIT 20
`define DSS_SLEEP_BIT 21
`define DSS_MOD_LO 8'h40
`define DSS_MOD_HI 8'h80
`define DSS_LOCK_TOL 4'h3
`endif

// >>> hdl/dss_pkg.sv
package dss_pkg;
  typedef enum logic [3:0] {
    DSS_PIN_OFF = 4'b0001,
    DSS_PIN_LOCK = 4'b0010,
    DSS_PIN_MON = 4'b0100,
    DSS_PIN_CTRL = 4'b1000
  } dss_pin_mode_t;
endpackage

// >>> bench/dss_program_logic_asserts.sv
`timescale 1ns/1ps
module dss_chk (
  // clock and control
  input wire logic clock,
  input wire logic rst,
  input wire logic loadStrobe,
  // watched outputs
  input wire logic [1:0] detectorPolarity,
  input wire logic [1:0] pumpCurrentHigh,
  input wire logic [1:0] prescalerHigh,
  input wire logic [1:0] pumpFloat,
  input wire logic [1:0] loopSleep,
  input wire logic [1:0] referenceTick,
  input wire logic [1:0] feedbackTick,
  input wire logic [1:0] pumpUp,
  input wire logic [1:0] pumpDown,
  input wire logic oscillatorEnable
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // six quiet samples outlast the strobe synchroniser and output register
  sequence quietStrobe;
    !loadStrobe [*6];
  endsequence
  a_fields_hold: assert property (quietStrobe |=>
    $stable({detectorPolarity, pumpCurrentHigh, prescalerHigh}))
    else $error("field changed without strobe");
  a_no_wake: assert property (quietStrobe |=> !$fell(loopSleep[0]) && !$fell(loopSleep[1]))
    else $error("loop woke without strobe");
  a_osc_run: assert property ((loopSleep != 2'h3) [*2] |-> oscillatorEnable)
    else $error("oscillator stopped with a loop awake");
  a_osc_stop: assert property ((loopSleep == 2'h3) [*2] |-> !oscillatorEnable)
    else $error("oscillator runs with both loops asleep");
  a_sleep_idle0: assert property (loopSleep[0] [*2] |-> !(referenceTick[0] || feedbackTick[0]))
    else $error("sleeping first loop divides");
  a_sleep_idle1: assert property (loopSleep[1] [*2] |-> !(referenceTick[1] || feedbackTick[1]))
    else $error("sleeping second loop divides");
  a_float_quiet0: assert property (pumpFloat[0] [*2] |-> !(pumpUp[0] || pumpDown[0]))
    else $error("floated first pump drives");
  a_float_quiet1: assert property (pumpFloat[1] [*2] |-> !(pumpUp[1] || pumpDown[1]))
    else $error("floated second pump drives");
endmodule
bind dss_program_logic dss_chk chk (.clock, .rst, .loadStrobe, .detectorPolarity,
  .pumpCurrentHigh, .prescalerHigh, .pumpFloat, .loopSleep, .referenceTick, .feedbackTick,
  .pumpUp, .pumpDown, .oscillatorEnable);

// >>> bench/dss_host_model.sv
`timescale 1ns/1ps
module dss_host_model (
  // serial link
  output logic serialClock,
  output logic serialData,
  output logic loadStrobe
);
  initial begin
    serialClock = 1'b0;
    serialData = 1'b0;
    loadStrobe = 1'b0;
  end
  // link clock only runs inside a frame
  task automatic send(input logic [21:0] word, input logic strobe);
    for (int i = 21; i >= 0; i--) begin
      serialData = word[i];
      #3 serialClock = 1'b1;
      #3 serialClock = 1'b0;
    end
    // released line: no pull, so show the opposite of the last bit
    serialData = ~word[0];
    if (strobe) begin
      #20 loadStrobe = 1'b1;
      #200 loadStrobe = 1'b0;
      #200;
    end
  endtask
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`include "dss_defines.svh"
module tb_top;
  logic clock, rst, serialClock, serialData, loadStrobe, oscillatorEnable, pin;
  logic [1:0] vcoPrescaled, pumpActive, detectorPolarity, pumpCurrentHigh, pumpFloat;
  logic [1:0] prescalerHigh, loopSleep, referenceTick, feedbackTick, pumpUp, pumpDown;
  int errors, n_tests, rises;
  logic prevPin;
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  dss_host_model host (.serialClock, .serialData, .loadStrobe);
  dss_program_logic dut (.clock, .rst, .serialClock, .serialData, .loadStrobe, .vcoPrescaled,
    .pumpActive, .detectorPolarity, .pumpCurrentHigh, .pumpFloat, .prescalerHigh, .loopSleep,
    .referenceTick, .feedbackTick, .pumpUp, .pumpDown, .oscillatorEnable,
    .multifunctionStatusPin(pin));
  always @(posedge clock) #1 vcoPrescaled = ~vcoPrescaled;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic load(input logic [21:0] w);
    host.send(w, 1'b1);
    @(posedge clock);
    #1;
  endtask
  // rising edges of the status pin over n clocks
  task automatic watch(input int n);
    rises = 0;
    prevPin = pin;
    repeat (n) begin
      @(posedge clock);
      #1;
      if (pin === 1'b1 && prevPin !== 1'b1) rises++;
      prevPin = pin;
    end
  endtask
  task automatic final_report;
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #300000;
    errors++;
    final_report;
  end
  initial begin
    rst = 1'b1;
    vcoPrescaled = 2'h0;
    pumpActive = 2'h0;
    repeat (8) @(posedge clock);
    #1 rst = 1'b0;
    check({1'b0, oscillatorEnable, loopSleep, pumpFloat, detectorPolarity}, 8'h40);
    // a stray frame with no strobe must fall out
    host.send(22'h3fffff, 1'b0);
    load({5'h05, 15'h0005, `DSS_SEL_REF1});
    check({2'h0, pumpFloat, pumpCurrentHigh, detectorPolarity}, 8'h11);
    load({5'h02, 15'h0003, `DSS_SEL_REF2});
    check({2'h0, pumpFloat, pumpCurrentHigh, detectorPolarity}, 8'h19);
    load({2'h1, 11'h004, 7'h02, `DSS_SEL_FB1});
    check({6'h0, prescalerHigh}, 8'h01);
    load({2'h1, 11'h005, 7'h03, `DSS_SEL_FB2});
    check({6'h0, prescalerHigh}, 8'h03);
    load({2'h0, 11'h004, 7'h02, `DSS_SEL_FB1});
    check({6'h0, prescalerHigh}, 8'h02);
    // first loop reference divider on the pin, ratio 5
    load({5'h11, 15'h0005, `DSS_SEL_REF1});
    watch(200);
    check({7'h0, rises >= 39 && rises <= 41}, 8'h01);
    load({5'h01, 15'h0005, `DSS_SEL_REF1});
    watch(100);
    check({7'h0, rises == 0 && pin === 1'b0}, 8'h01);
    // floated pumps: sleep takes effect at once
    load({5'h04, 15'h0003, `DSS_SEL_REF2});
    load({5'h05, 15'h0005, `DSS_SEL_REF1});
    load({2'h2, 11'h004, 7'h02, `DSS_SEL_FB1});
    load({2'h2, 11'h005, 7'h03, `DSS_SEL_FB2});
    check({5'h0, oscillatorEnable, loopSleep}, 8'h03);
    load({2'h0, 11'h004, 7'h02, `DSS_SEL_FB1});
    check({5'h0, oscillatorEnable, loopSleep}, 8'h06);
    // pump left driving: sleep waits for it
    load({5'h01, 15'h0005, `DSS_SEL_REF1});
    pumpActive = 2'h1;
    load({2'h2, 11'h004, 7'h02, `DSS_SEL_FB1});
    check({5'h0, oscillatorEnable, loopSleep}, 8'h06);
    pumpActive = 2'h0;
    repeat (4) @(posedge clock);
    #1;
    check({5'h0, oscillatorEnable, loopSleep}, 8'h03);
    // both function bits: first loop counters reset, then fast acquisition
    load({5'h12, 15'h0005, `DSS_SEL_REF2});
    load({5'h18, 15'h0005, `DSS_SEL_REF1});
    check({5'h0, pin, pumpFloat}, 8'h01);
    load({5'h10, 15'h0005, `DSS_SEL_REF1});
    check({5'h0, pin, pumpFloat}, 8'h04);
    // lock indication of the first loop, whose pumps are idle
    load({5'h02, 15'h0005, `DSS_SEL_REF2});
    load({5'h08, 15'h0005, `DSS_SEL_REF1});
    check({7'h0, pin}, 8'h01);
    // first loop feedback divider: 64*4+2 prescaler pulses, one every 2 clocks
    load({5'h08, 15'h0003, `DSS_SEL_REF2});
    load({5'h10, 15'h0005, `DSS_SEL_REF1});
    load({2'h0, 11'h004, 7'h02, `DSS_SEL_FB1});
    watch(1100);
    check({7'h0, rises >= 2 && rises <= 3}, 8'h01);
    final_report;
  end
endmodule
